// file: design/host_port_defines.vh
`ifndef HOST_PORT_DEFINES_VH
`define HOST_PORT_DEFINES_VH

// Bus widths
`define HP_DATA_W 8
`define HP_ADDR_W 3

// Reset values
`define HP_RST_BYTE 8'h00
`define HP_RST_ADDR 3'h0

// Timing in cycles from strobe sample to data out register
`define HP_RD_LAT 1

`endif

// file: design/sel_latch.v
`include "host_port_defines.vh"

// Transparent or strobe-captured hold of selects and register index
module sel_latch #(
  parameter W = 6
) (
  // Clock and reset
  input  wire         clk,
  input  wire         sys_rst,
  // Strobe and raw inputs
  input  wire         addr_latch_strobe,
  input  wire [W-1:0] raw_in,
  // Effective value
  output wire [W-1:0] eff_out
);

  reg [W-1:0] held_ff;
  reg         strobe_ff;

  // Capture on rising strobe; held copy is only used while strobe is high
  always @(posedge clk) begin
    if (sys_rst) begin
      held_ff   <= {W{1'b0}};
      strobe_ff <= 1'b0;
    end else begin
      strobe_ff <= addr_latch_strobe;
      if (addr_latch_strobe && !strobe_ff) begin
        held_ff <= raw_in;
      end
    end
  end

  assign eff_out = addr_latch_strobe ? (strobe_ff ? held_ff : raw_in) : raw_in;

endmodule // sel_latch

// file: design/uart_host_bus_port.v
`include "host_port_defines.vh"

module uart_host_bus_port #(
  parameter DW = `HP_DATA_W,
  parameter AW = `HP_ADDR_W
) (
  // Clock and reset
  input  wire          clk,
  input  wire          sys_rst,
  // Register select bits
  input  wire          reg_sel_bit0,
  input  wire          reg_sel_bit1,
  input  wire          reg_sel_bit2,
  // Chip selects and address strobe
  input  wire          sel_hi_a,
  input  wire          sel_hi_b,
  input  wire          sel_lo,
  input  wire          addr_latch_strobe,
  // Strobes
  input  wire          rd_strobe_hi,
  input  wire          rd_strobe_lo,
  input  wire          wr_strobe_hi,
  input  wire          wr_strobe_lo,
  // Host data bus, split
  input  wire [DW-1:0] host_data_bus_in,
  output reg  [DW-1:0] host_data_bus_out,
  output reg           host_data_bus_oe_n,
  // Internal register side
  output reg  [AW-1:0] reg_addr,
  output reg           reg_wr_pulse,
  output reg  [DW-1:0] reg_wr_data,
  output reg           reg_rd_pulse,
  input  wire [DW-1:0] reg_rd_data
);

  // Packed select word: three chip selects above the index
  localparam SW = AW + 3;

  // Bus cycle seen at the previous edge
  localparam ST_IDLE  = 2'b00;
  localparam ST_READ  = 2'b01;
  localparam ST_WRITE = 2'b10;
  localparam ST_BLOCK = 2'b11;

  // Raw pins gathered into one word
  wire [AW-1:0] raw_index;
  wire [2:0]    raw_chip;
  wire [SW-1:0] raw_sel;

  // Effective selects after the address strobe latch
  wire [SW-1:0] eff_sel;
  wire [AW-1:0] eff_index;
  wire          eff_sel_hi_a;
  wire          eff_sel_hi_b;
  wire          eff_sel_lo;

  // Decoded request terms
  wire          selected;
  wire          rd_req;
  wire          wr_req;
  wire          collide;
  wire          rd_ok;
  wire          wr_ok;

  // Cycle tracker
  reg  [1:0]    state_ff;
  reg  [1:0]    nxt_state;

  // Next values of the registered outputs
  reg  [DW-1:0] nxt_bus_out;
  reg           nxt_oe_n;
  reg  [AW-1:0] nxt_addr;
  reg           nxt_wr_pulse;
  reg  [DW-1:0] nxt_wr_data;
  reg           nxt_rd_pulse;

  // index bit order, bit0 is LSB
  assign raw_index = {reg_sel_bit2, reg_sel_bit1, reg_sel_bit0};

  // Chip selects ride above the index so one latch serves all six
  assign raw_chip  = {sel_hi_a, sel_hi_b, sel_lo};
  assign raw_sel   = {raw_chip, raw_index};

  // Selects and index share one capture edge; strobes are never latched
  sel_latch #(
    .W (SW)
  ) u_sel_latch (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .addr_latch_strobe (addr_latch_strobe),
    .raw_in            (raw_sel),
    .eff_out           (eff_sel)
  );

  // Split the effective word back into its fields
  assign eff_index    = eff_sel[AW-1:0];
  assign eff_sel_lo   = eff_sel[AW];
  assign eff_sel_hi_b = eff_sel[AW+1];
  assign eff_sel_hi_a = eff_sel[AW+2];

  assign selected = eff_sel_hi_a & eff_sel_hi_b & ~eff_sel_lo;

  // Strobes come straight from the pins, only selects and index are latched
  // either read polarity
  assign rd_req = rd_strobe_hi | ~rd_strobe_lo;

  assign wr_req = wr_strobe_hi | ~wr_strobe_lo;

  assign collide = rd_req & wr_req;
  assign rd_ok   = selected & rd_req & ~collide;
  assign wr_ok   = selected & wr_req & ~collide;

  // Remember the kind of cycle so a held strobe gives only one pulse
  // ST_BLOCK is held for as long as both strobes stay up
  always @* begin
    if (rd_ok) begin
      nxt_state = ST_READ;
    end else if (wr_ok) begin
      nxt_state = ST_WRITE;
    end else if (collide) begin
      // Both strobes: neither side may act
      nxt_state = ST_BLOCK;
    end else begin
      nxt_state = ST_IDLE;
    end
  end

  // store bus byte once
  // A long strobe must not pop a FIFO twice, so only a new cycle pulses
  always @* begin
    nxt_rd_pulse = 1'b0;
    nxt_wr_pulse = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        nxt_rd_pulse = rd_ok;
        nxt_wr_pulse = wr_ok;
      end
      ST_READ: begin
        // Same read strobe still held
        nxt_rd_pulse = 1'b0;
        nxt_wr_pulse = wr_ok;
      end
      ST_WRITE: begin
        // Same write strobe still held
        nxt_rd_pulse = rd_ok;
        nxt_wr_pulse = 1'b0;
      end
      ST_BLOCK: begin
        // Collision over: a strobe left alone starts a new cycle
        nxt_rd_pulse = rd_ok;
        nxt_wr_pulse = wr_ok;
      end
      default: begin
        nxt_rd_pulse = 1'b0;
        nxt_wr_pulse = 1'b0;
      end
    endcase
  end

  // Data path next values
  // The read byte trails the drive enable by one cycle of reg_rd_data
  always @* begin
    nxt_addr    = eff_index;
    nxt_wr_data = host_data_bus_in;
    nxt_bus_out = reg_rd_data;
    nxt_oe_n    = ~rd_ok;
  end

  // Cycle state register
  always @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Host bus outputs, registered so the pins never show a decode glitch
  always @(posedge clk) begin
    if (sys_rst) begin
      host_data_bus_out  <= `HP_RST_BYTE;
      host_data_bus_oe_n <= 1'b1;
    end else begin
      host_data_bus_out  <= nxt_bus_out;
      host_data_bus_oe_n <= nxt_oe_n;
    end
  end

  // Register side outputs; the data copy moves freely, only the pulse commits
  always @(posedge clk) begin
    if (sys_rst) begin
      reg_addr     <= `HP_RST_ADDR;
      reg_wr_pulse <= 1'b0;
      reg_wr_data  <= `HP_RST_BYTE;
      reg_rd_pulse <= 1'b0;
    end else begin
      reg_addr     <= nxt_addr;
      reg_wr_pulse <= nxt_wr_pulse;
      reg_wr_data  <= nxt_wr_data;
      reg_rd_pulse <= nxt_rd_pulse;
    end
  end

endmodule // uart_host_bus_port

// file: verification/reg_model.sv
module reg_model (
  input wire logic       clk, reg_wr_pulse,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic     [7:0] reg_rd_data
);
  timeunit 1ns; timeprecision 1ps;
  logic [7:0] mem_ff [8];
  always @(posedge clk) if (reg_wr_pulse) mem_ff[reg_addr] <= reg_wr_data;
  assign reg_rd_data = mem_ff[reg_addr];
endmodule // reg_model

// file: verification/uart_host_bus_port_properties.sv
module port_props (
  // Host side, with the two register data bytes
  input wire logic       clk, sys_rst, reg_sel_bit0, reg_sel_bit1, reg_sel_bit2,
  input wire logic       sel_hi_a, sel_hi_b, sel_lo, addr_latch_strobe,
  input wire logic       rd_strobe_hi, rd_strobe_lo, wr_strobe_hi, wr_strobe_lo,
  input wire logic [7:0] host_data_bus_in, host_data_bus_out, reg_rd_data, reg_wr_data,
  // Register side, with the host bus drive enable
  input wire logic       host_data_bus_oe_n, reg_wr_pulse, reg_rd_pulse,
  input wire logic [2:0] reg_addr
);
  timeunit 1ns; timeprecision 1ps;
  // Decoded strobes; latched cycles are left out since raw lines lie then
  wire cs = sel_hi_a & sel_hi_b & ~sel_lo;
  wire pt = ~addr_latch_strobe;
  wire rd = rd_strobe_hi | ~rd_strobe_lo;
  wire wr = wr_strobe_hi | ~wr_strobe_lo;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_read_drive: assert property (pt && cs && rd && !wr |=> !host_data_bus_oe_n)
    else $error("read not driven");
  a_read_pulse: assert property ($rose(cs && rd && !wr) && pt |=> reg_rd_pulse)
    else $error("no read pulse");
  a_write_store: assert property ($rose(cs && wr && !rd) && pt |=>
    reg_wr_pulse && reg_wr_data == $past(host_data_bus_in)) else $error("write lost");
  a_both_strobes: assert property (rd && wr |=>
    host_data_bus_oe_n && !reg_wr_pulse && !reg_rd_pulse) else $error("collision acted");
  a_not_selected: assert property (pt && !cs |=> host_data_bus_oe_n && !reg_wr_pulse)
    else $error("acted unselected");
  a_index_pass: assert property (pt |=>
    reg_addr == $past({reg_sel_bit2, reg_sel_bit1, reg_sel_bit0})) else $error("index");
  a_index_held: assert property (addr_latch_strobe && $past(addr_latch_strobe) |=>
    $stable(reg_addr)) else $error("latched index moved");
  a_out_follow: assert property (!host_data_bus_oe_n |=>
    host_data_bus_out == $past(reg_rd_data)) else $error("read byte wrong");
endmodule // port_props

bind uart_host_bus_port port_props props (.*);

// file: verification/uart_host_bus_port_tb_top.sv
module uart_host_bus_port_tb_top;
  timeunit 1ns; timeprecision 1ps;
  logic clk = 0, sys_rst = 1, reg_sel_bit0 = 0, reg_sel_bit1 = 0, reg_sel_bit2 = 0;
  logic sel_hi_a = 1, sel_hi_b = 1, sel_lo = 0, addr_latch_strobe = 0;
  logic rd_strobe_hi = 0, rd_strobe_lo = 1, wr_strobe_hi = 0, wr_strobe_lo = 1;
  logic [7:0] host_data_bus_in = 8'h00, host_data_bus_out, reg_wr_data, reg_rd_data;
  logic [2:0] reg_addr;
  logic       host_data_bus_oe_n, reg_wr_pulse, reg_rd_pulse;
  int n_errors = 0, comparisons = 0;
  always #12.5 clk = ~clk;
  uart_host_bus_port dut (.*);
  reg_model mdl (.*);
  task automatic chk(input string nm, input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(int n = 1); repeat (n) @(posedge clk); #2; endtask
  function automatic logic [7:0] ev(int i); return 8'h11 * i[7:0] ^ 8'ha5; endfunction
  // One access; hi picks the strobe polarity, the other stays idle
  task automatic acc(input bit hi, wr, input logic [2:0] a, input logic [7:0] d);
    {reg_sel_bit2, reg_sel_bit1, reg_sel_bit0} = a;
    host_data_bus_in = d;
    if (wr) {wr_strobe_hi, wr_strobe_lo} = {hi, hi};
    else {rd_strobe_hi, rd_strobe_lo} = {hi, hi};
    tick();
    chk("addr", reg_addr, a);
    chk("pulse", wr ? reg_wr_pulse : reg_rd_pulse, 1);
    if (wr) chk("wdata", reg_wr_data, d);
    else chk("oe_n", host_data_bus_oe_n, 0);
    tick();
    if (!wr) chk("rdata", host_data_bus_out, d);
    {wr_strobe_hi, wr_strobe_lo, rd_strobe_hi, rd_strobe_lo} = 4'b0101;
    tick();
    chk("release", host_data_bus_oe_n, 1);
  endtask
  task automatic t_rw;
    for (int i = 0; i < 8; i++) acc(i[0], 1, i[2:0], ev(i));
    for (int i = 0; i < 8; i++) acc(~i[0], 0, i[2:0], ev(i));
    $display("rw done");
  endtask
  // Each select dropped in turn, then read and write together
  task automatic t_refuse;
    for (int k = 0; k < 4; k++) begin
      // one select dropped at a time for k below 3, the other two tied active; all three active for k == 3
      {sel_hi_a, sel_hi_b, sel_lo} = k == 0 ? 3'b010 : k == 1 ? 3'b100 : k == 2 ? 3'b111 : 3'b110;
      // Write, read, write unselected; then both strobes while selected
      {wr_strobe_lo, rd_strobe_lo, host_data_bus_in} = {k == 1, k != 1 && k != 3, 8'h3c};
      tick();
      chk("wr_pulse", reg_wr_pulse, 0);
      chk("rd_pulse", reg_rd_pulse, 0);
      chk("oe_n", host_data_bus_oe_n, 1);
      {sel_hi_a, sel_hi_b, sel_lo, wr_strobe_lo, rd_strobe_lo} = 5'b11011;
      tick();
    end
    acc(0, 0, 0, ev(0));
    $display("refuse done");
  endtask
  // Index captured on the strobe's rise, then moved under it
  task automatic t_latch;
    {reg_sel_bit2, reg_sel_bit1, reg_sel_bit0, addr_latch_strobe} = 4'b0111;
    tick();
    // Raw index and one raw select move away; the captured ones must rule
    {sel_hi_a, reg_sel_bit2, reg_sel_bit1, reg_sel_bit0, rd_strobe_lo} = 5'b01010;
    tick(2);
    chk("latched", reg_addr, 3);
    chk("lsel", host_data_bus_oe_n, 0);
    chk("ldata", host_data_bus_out, ev(3));
    {sel_hi_a, rd_strobe_lo, addr_latch_strobe} = 3'b110;
    tick(2);
    chk("lrelease", host_data_bus_oe_n, 1);
    chk("lpass", reg_addr, 5);
    $display("latch done");
  endtask
  // Reset lands in the middle of a read, then is released
  task automatic t_reset;
    rd_strobe_lo = 0;
    tick();
    sys_rst = 1;
    tick(2);
    chk("rst_oe_n", host_data_bus_oe_n, 1);
    chk("rst_out", host_data_bus_out, 0);
    chk("rst_pulses", {reg_wr_pulse, reg_rd_pulse}, 0);
    chk("rst_addr", reg_addr, 0);
    chk("rst_wdata", reg_wr_data, 0);
    {sys_rst, rd_strobe_lo} = 2'b01;
    tick();
    chk("rst_idle", host_data_bus_oe_n, 1);
    $display("reset done");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    tick(16);
    chk("init_oe_n", host_data_bus_oe_n, 1);
    sys_rst = 0;
    tick();
    t_rw;
    t_refuse;
    t_reset;
    t_latch;
    wrap_up;
  end
  initial begin
    #100us n_errors++;
    wrap_up;
  end
endmodule // uart_host_bus_port_tb_top
